// ==== design/rtcal_unit.sv ====
// Purpose: alarm unit of the real-time clock with an AXI4-Lite register slave
// Assumes: calendar counters and prescaler run on aclk and feed this block directly
// Notes:   alarm control and setting survive aresetn; only power_on_n clears them
//
// Summary of operation
// - arm bit enables alarm events
// - chime wraps countdown 0x00 to 0xFF
// - no chime: countdown halts at 0x00
// - disarmed: pulse start bit writable, sets level
// - armed: pulse bit ignores writes, reads level
// - near flag set when rollover may disturb
// - flag clear only beyond 32 rtc clocks
// - interval field selects alarm period
// - yearly february 29 fires every fourth year
// - last event without chime clears arm
// - control resets only at power-on
// - hour digits at bits 29-24
// - minute digits at bits 22-16
// - second digits at bits 14-8
// - unimplemented bits read zero
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`default_nettype none

module rtcal_unit
   import rtcal_pkg::*;
(
   // clock and resets
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        power_on_n,
   // calendar inputs
   input  wire logic        half_tick,
   input  wire logic        second_half,
   input  wire logic [15:0] rtc_clocks_to_rollover,
   input  wire logic [31:0] now_time,
   input  wire logic [31:0] now_date,
   // alarm outputs
   output logic             alarm_pulse,
   output logic             alarm_event,
   // axi4-lite write address
   input  wire logic        s_axil_awvalid,
   output logic             s_axil_awready,
   input  wire logic [7:0]  s_axil_awaddr,
   // axi4-lite write data
   input  wire logic        s_axil_wvalid,
   output logic             s_axil_wready,
   input  wire logic [31:0] s_axil_wdata,
   input  wire logic [3:0]  s_axil_wstrb,
   // axi4-lite write response
   output logic             s_axil_bvalid,
   input  wire logic        s_axil_bready,
   output logic [1:0]       s_axil_bresp,
   // axi4-lite read address
   input  wire logic        s_axil_arvalid,
   output logic             s_axil_arready,
   input  wire logic [7:0]  s_axil_araddr,
   // axi4-lite read data
   output logic             s_axil_rvalid,
   input  wire logic        s_axil_rready,
   output logic [31:0]      s_axil_rdata,
   output logic [1:0]       s_axil_rresp
);

   typedef struct packed {
      logic        alarm_arm;
      logic        chime;
      logic        pulse;
      logic [3:0]  match_interval_select;
      logic [7:0]  repeat_countdown;
      logic [31:0] alarm_time;
      logic [31:0] alarm_date;
      logic        event_q;
      logic        aw_held;
      logic [7:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } rtcal_state_t;

   rtcal_state_t st;
   rtcal_state_t next_st;

   logic        match;
   logic        hit;
   logic        rollover_near_flag;
   logic        wr_go;
   logic        wr_ctl;
   logic [31:0] ctl_word;

   function automatic logic [31:0] rtcal_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : rtcal_merge

   rtcal_match u_match (
      .match_interval_select (st.match_interval_select),
      .half_tick             (half_tick),
      .second_half           (second_half),
      .alarm_time            (st.alarm_time),
      .alarm_date            (st.alarm_date),
      .now_time              (now_time),
      .now_date              (now_date),
      .match                 (match)
   );

   assign hit = st.alarm_arm && match;

   // warn software while the half-second rollover can still reach the synced copy
   assign rollover_near_flag = rtc_clocks_to_rollover <= NEAR_GUARD;

   assign wr_go  = st.aw_held && st.w_held && !st.bvalid;
   assign wr_ctl = wr_go && st.aw_addr == ADDR_CONTROL;

   always_comb begin
      ctl_word = REG_RESET;
      ctl_word[CTL_ARM_BIT]             = st.alarm_arm;
      ctl_word[CTL_CHIME_BIT]           = st.chime;
      ctl_word[CTL_PULSE_BIT]           = st.pulse;
      ctl_word[CTL_NEAR_BIT]            = rollover_near_flag;
      ctl_word[CTL_SEL_LSB +: 4]        = st.match_interval_select;
      ctl_word[CTL_RPT_LSB +: 8]        = st.repeat_countdown;
   end

   assign s_axil_awready = !st.aw_held && !st.bvalid;
   assign s_axil_wready  = !st.w_held && !st.bvalid;
   assign s_axil_arready = !st.rvalid;
   assign s_axil_bvalid  = st.bvalid;
   assign s_axil_bresp   = st.bresp;
   assign s_axil_rvalid  = st.rvalid;
   assign s_axil_rdata   = st.rdata;
   assign s_axil_rresp   = st.rresp;
   assign alarm_pulse    = st.pulse;
   assign alarm_event    = st.event_q;

   always_comb begin
      logic [31:0] merged;
      merged  = REG_RESET;
      next_st = st;

      // write channel capture, address and data in either order
      if (s_axil_awvalid && s_axil_awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axil_wdata;
         next_st.w_strb = s_axil_wstrb;
      end
      if (s_axil_bvalid && s_axil_bready) begin
         next_st.bvalid = 1'b0;
      end

      if (wr_go) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = RESP_OKAY;
         if (st.aw_addr == ADDR_CONTROL) begin
            merged = rtcal_merge(ctl_word, st.w_data, st.w_strb);
            next_st.alarm_arm             = merged[CTL_ARM_BIT];
            next_st.chime                 = merged[CTL_CHIME_BIT];
            next_st.match_interval_select = merged[CTL_SEL_LSB +: 4];
            next_st.repeat_countdown      = merged[CTL_RPT_LSB +: 8];
            // the level only follows software while the alarm is idle
            if (!st.alarm_arm) begin
               next_st.pulse = merged[CTL_PULSE_BIT];
            end
         end else if (st.aw_addr == ADDR_TIME) begin
            merged = rtcal_merge(st.alarm_time, st.w_data, st.w_strb);
            next_st.alarm_time = merged & TIM_MASK;
         end else if (st.aw_addr == ADDR_DATE) begin
            merged = rtcal_merge(st.alarm_date, st.w_data, st.w_strb);
            next_st.alarm_date = merged & DAT_MASK;
         end else begin
            next_st.bresp = RESP_SLVERR;
         end
      end

      // read channel: data sampled at the address handshake
      if (s_axil_rvalid && s_axil_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axil_arvalid && s_axil_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = RESP_OKAY;
         if (s_axil_araddr == ADDR_CONTROL) begin
            next_st.rdata = ctl_word;
         end else if (s_axil_araddr == ADDR_TIME) begin
            next_st.rdata = st.alarm_time & TIM_MASK;
         end else if (s_axil_araddr == ADDR_DATE) begin
            next_st.rdata = st.alarm_date & DAT_MASK;
         end else begin
            next_st.rdata = REG_RESET;
            next_st.rresp = RESP_SLVERR;
         end
      end

      // the alarm event is applied last so hardware wins over a same-cycle write
      next_st.event_q = hit;
      if (hit) begin
         next_st.pulse = !st.pulse;
         if (st.repeat_countdown != RPT_RESET) begin
            next_st.repeat_countdown = st.repeat_countdown - 8'h01;
         end else if (st.chime) begin
            next_st.repeat_countdown = RPT_WRAP;
         end else begin
            next_st.repeat_countdown = RPT_RESET;
            next_st.alarm_arm        = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!power_on_n) begin
         next_st_reset_all: begin
            st <= '0;
         end
      end else if (!aresetn) begin
         // alarm setting kept; only the bus side and the event strobe restart
         st         <= next_st;
         st.event_q <= 1'b0;
         st.aw_held <= 1'b0;
         st.w_held  <= 1'b0;
         st.bvalid  <= 1'b0;
         st.rvalid  <= 1'b0;
         st.bresp   <= RESP_OKAY;
         st.rresp   <= RESP_OKAY;
         st.rdata   <= REG_RESET;
         st.alarm_arm             <= st.alarm_arm;
         st.chime                 <= st.chime;
         st.pulse                 <= st.pulse;
         st.match_interval_select <= st.match_interval_select;
         st.repeat_countdown      <= st.repeat_countdown;
         st.alarm_time            <= st.alarm_time;
         st.alarm_date            <= st.alarm_date;
      end else begin
         st <= next_st;
      end
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !power_on_n);

   arm_gates_event_a: assert property (alarm_event |-> $past(st.alarm_arm))
      else $error("alarm event without arm");
   chime_wrap_a: assert property (hit && st.chime && st.repeat_countdown == 8'h00
         |=> st.repeat_countdown == 8'hFF)
      else $error("countdown did not wrap under chime");
   halt_disarm_a: assert property (hit && !st.chime && st.repeat_countdown == 8'h00
         |=> st.repeat_countdown == 8'h00 && !st.alarm_arm)
      else $error("last event did not halt and disarm");
   count_down_a: assert property (hit && st.repeat_countdown != 8'h00 && !wr_ctl
         |=> st.repeat_countdown == $past(st.repeat_countdown) - 8'h01)
      else $error("countdown did not step");
   pulse_toggle_a: assert property (hit |=> alarm_pulse != $past(alarm_pulse) ##0 alarm_event)
      else $error("event did not toggle pulse");
   pulse_hold_a: assert property (st.alarm_arm && !hit |=> alarm_pulse == $past(alarm_pulse))
      else $error("pulse level changed while armed without event");
   pulse_write_a: assert property (wr_ctl && !st.alarm_arm && !hit && st.w_strb[1]
         |=> alarm_pulse == $past(st.w_data[13]))
      else $error("pulse start value not taken");
   near_read_a: assert property (s_axil_arvalid && s_axil_arready && s_axil_araddr == 8'h00
         |=> s_axil_rdata[12] == ($past(rtc_clocks_to_rollover) <= 16'h0020))
      else $error("rollover flag read wrong");
   reserved_zero_a: assert property (s_axil_rvalid |-> s_axil_rdata[31:30] == 2'h0
         && s_axil_rdata[23] == 1'b0)
      else $error("reserved bits read nonzero");
   write_resp_a: assert property (wr_go |=> s_axil_bvalid [*1] ##0 !s_axil_awready)
      else $error("write response missing");

   wrap_seen_c:   cover property (hit && st.chime && st.repeat_countdown == 8'h00);
   disarm_seen_c: cover property (hit && !st.chime && st.repeat_countdown == 8'h00);
   ctl_read_c:    cover property (s_axil_rvalid && s_axil_rready && rollover_near_flag);

endmodule : rtcal_unit

`default_nettype wire

// ==== design/rtcal_pkg.sv ====
// Purpose: shared constants and types of the alarm unit of the real-time clock
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes:   register fields are kept as positions and masks so both files agree
`default_nettype none

package rtcal_pkg;

   // register byte addresses
   localparam logic [7:0]  ADDR_CONTROL     = 8'h00;
   localparam logic [7:0]  ADDR_TIME        = 8'h04;
   localparam logic [7:0]  ADDR_DATE        = 8'h08;

   // alarm control fields
   localparam int          CTL_ARM_BIT      = 15;
   localparam int          CTL_CHIME_BIT    = 14;
   localparam int          CTL_PULSE_BIT    = 13;
   localparam int          CTL_NEAR_BIT     = 12;
   localparam int          CTL_SEL_LSB      = 8;
   localparam int          CTL_RPT_LSB      = 0;

   // alarm time fields (bcd digits)
   localparam int          TIM_HR_T_LSB     = 28;
   localparam int          TIM_HR_U_LSB     = 24;
   localparam int          TIM_MN_T_LSB     = 20;
   localparam int          TIM_MN_U_LSB     = 16;
   localparam int          TIM_SC_T_LSB     = 12;
   localparam int          TIM_SC_U_LSB     = 8;
   localparam logic [31:0] TIM_MASK         = 32'h3F7F7F00;

   // alarm date fields (bcd digits, weekday binary)
   localparam int          DAT_MO_T_LSB     = 20;
   localparam int          DAT_MO_U_LSB     = 16;
   localparam int          DAT_DY_T_LSB     = 12;
   localparam int          DAT_DY_U_LSB     = 8;
   localparam int          DAT_WD_LSB       = 0;
   localparam logic [31:0] DAT_MASK         = 32'h001F3F07;

   // reset and wrap values
   localparam logic [7:0]  RPT_RESET        = 8'h00;
   localparam logic [7:0]  RPT_WRAP         = 8'hFF;
   localparam logic [3:0]  SEL_RESET        = 4'h0;
   localparam logic [31:0] REG_RESET        = 32'h00000000;

   // rollover guard band in rtc clocks
   localparam logic [15:0] NEAR_GUARD       = 16'h0020;

   // axi responses
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   // match interval codes
   typedef enum logic [3:0] {
      SEL_HALF_SEC  = 4'h0,
      SEL_SECOND    = 4'h1,
      SEL_TEN_SEC   = 4'h2,
      SEL_MINUTE    = 4'h3,
      SEL_TEN_MIN   = 4'h4,
      SEL_HOUR      = 4'h5,
      SEL_DAY       = 4'h6,
      SEL_WEEK      = 4'h7,
      SEL_MONTH     = 4'h8,
      SEL_YEAR      = 4'h9
   } rtcal_sel_t;

endpackage : rtcal_pkg

`default_nettype wire

// ==== design/rtcal_match.sv ====
// Purpose: decides whether the current calendar time hits the alarm setting
// Assumes: time inputs already hold the new value in the cycle of the half tick
// Notes:   purely combinational; reserved interval codes never match
`default_nettype none

module rtcal_match
   import rtcal_pkg::*;
(
   // selection
   input  wire logic [3:0]  match_interval_select,
   input  wire logic        half_tick,
   input  wire logic        second_half,
   // stored alarm setting
   input  wire logic [31:0] alarm_time,
   input  wire logic [31:0] alarm_date,
   // current calendar
   input  wire logic [31:0] now_time,
   input  wire logic [31:0] now_date,
   // result
   output logic             match
);

   logic sc_u_eq;
   logic sc_t_eq;
   logic mn_u_eq;
   logic mn_t_eq;
   logic hr_eq;
   logic wd_eq;
   logic dy_eq;
   logic mo_eq;
   logic whole_sec;

   assign sc_u_eq   = alarm_time[TIM_SC_U_LSB +: 4] == now_time[TIM_SC_U_LSB +: 4];
   assign sc_t_eq   = alarm_time[TIM_SC_T_LSB +: 3] == now_time[TIM_SC_T_LSB +: 3];
   assign mn_u_eq   = alarm_time[TIM_MN_U_LSB +: 4] == now_time[TIM_MN_U_LSB +: 4];
   assign mn_t_eq   = alarm_time[TIM_MN_T_LSB +: 3] == now_time[TIM_MN_T_LSB +: 3];
   assign hr_eq     = alarm_time[TIM_HR_U_LSB +: 6] == now_time[TIM_HR_U_LSB +: 6];
   assign wd_eq     = alarm_date[DAT_WD_LSB +: 3] == now_date[DAT_WD_LSB +: 3];
   assign dy_eq     = alarm_date[DAT_DY_U_LSB +: 6] == now_date[DAT_DY_U_LSB +: 6];
   assign mo_eq     = alarm_date[DAT_MO_U_LSB +: 5] == now_date[DAT_MO_U_LSB +: 5];
   assign whole_sec = half_tick && !second_half;

   // each wider interval compares one more calendar field; month compares the day in place of the weekday
   always_comb begin
      case (match_interval_select)
         SEL_HALF_SEC: match = half_tick;
         SEL_SECOND:   match = whole_sec;
         SEL_TEN_SEC:  match = whole_sec && sc_u_eq;
         SEL_MINUTE:   match = whole_sec && sc_u_eq && sc_t_eq;
         SEL_TEN_MIN:  match = whole_sec && sc_u_eq && sc_t_eq && mn_u_eq;
         SEL_HOUR:     match = whole_sec && sc_u_eq && sc_t_eq && mn_u_eq && mn_t_eq;
         SEL_DAY:      match = whole_sec && sc_u_eq && sc_t_eq && mn_u_eq && mn_t_eq && hr_eq;
         SEL_WEEK:     match = whole_sec && sc_u_eq && sc_t_eq && mn_u_eq && mn_t_eq && hr_eq
                               && wd_eq;
         SEL_MONTH:    match = whole_sec && sc_u_eq && sc_t_eq && mn_u_eq && mn_t_eq && hr_eq
                               && dy_eq;
         // a 29th of february only exists in leap years, so it fires every fourth year
         SEL_YEAR:     match = whole_sec && sc_u_eq && sc_t_eq && mn_u_eq && mn_t_eq && hr_eq
                               && dy_eq && mo_eq;
         default:      match = 1'b0;
      endcase
   end

endmodule : rtcal_match

`default_nettype wire

// ==== design/rtcal_unit_fix.sv ====
// Purpose: none
// Assumes: none
// Notes:   none
`default_nettype none
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench of the alarm unit through its register bus and alarm pins
// Assumes: one 10 MHz clock; both resets synchronous and active low
// Notes:   random alarm settings come from a fixed-seed lfsr, corner cases are hand-written
`default_nettype none

module tb_top
   import rtcal_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        aclk                   = 1'h0;
   logic        aresetn                = 1'h0;
   logic        power_on_n             = 1'h0;
   logic        half_tick              = 1'h0;
   logic        second_half            = 1'h0;
   logic [15:0] rtc_clocks_to_rollover = 16'h0064;
   logic [31:0] now_time               = 32'h0;
   logic [31:0] now_date               = 32'h0;
   logic        alarm_pulse;
   logic        alarm_event;
   logic        s_axil_awvalid         = 1'h0;
   logic        s_axil_awready;
   logic [7:0]  s_axil_awaddr          = 8'h0;
   logic        s_axil_wvalid          = 1'h0;
   logic        s_axil_wready;
   logic [31:0] s_axil_wdata           = 32'h0;
   logic [3:0]  s_axil_wstrb           = 4'hF;
   logic        s_axil_bvalid;
   logic        s_axil_bready          = 1'h0;
   logic [1:0]  s_axil_bresp;
   logic        s_axil_arvalid         = 1'h0;
   logic        s_axil_arready;
   logic [7:0]  s_axil_araddr          = 8'h0;
   logic        s_axil_rvalid;
   logic        s_axil_rready          = 1'h0;
   logic [31:0] s_axil_rdata;
   logic [1:0]  s_axil_rresp;
   logic [15:0] lfsr_q                 = 16'hDB73;
   int          error_cnt              = 0;
   int          n_compared             = 0;

   rtcal_unit dut (
      .aclk, .aresetn, .power_on_n, .half_tick, .second_half, .rtc_clocks_to_rollover,
      .now_time, .now_date, .alarm_pulse, .alarm_event,
      .s_axil_awvalid, .s_axil_awready, .s_axil_awaddr,
      .s_axil_wvalid, .s_axil_wready, .s_axil_wdata, .s_axil_wstrb,
      .s_axil_bvalid, .s_axil_bready, .s_axil_bresp,
      .s_axil_arvalid, .s_axil_arready, .s_axil_araddr,
      .s_axil_rvalid, .s_axil_rready, .s_axil_rdata, .s_axil_rresp
   );

   initial begin
      forever #50 aclk = ~aclk;
   end

   function logic [15:0] rnd();
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      return lfsr_q;
   endfunction : rnd

   // legal bcd digits only; the unused bits are filled with ones by the caller
   function automatic logic [31:0] rnd_time();
      return {2'h0, 2'(rnd() % 3), 4'(rnd() % 10), 1'h0, 3'(rnd() % 6), 4'(rnd() % 10),
              1'h0, 3'(rnd() % 6), 4'(rnd() % 10), 8'h00};
   endfunction : rnd_time

   function automatic logic [31:0] rnd_date();
      return {11'h0, 1'(rnd() % 2), 4'(rnd() % 10), 2'h0, 2'(rnd() % 4), 4'(rnd() % 10),
              5'h0, 3'(rnd() % 7)};
   endfunction : rnd_date

   function automatic logic [31:0] ctl(input logic arm, chime, pv, near,
                                       input logic [3:0] sel, input logic [7:0] rpt);
      return {16'h0000, arm, chime, pv, near, sel, rpt};
   endfunction : ctl

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic chk_flag(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk_flag

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_t;
      logic w_t;
      int   n;
      @(posedge aclk);
      s_axil_awvalid <= 1'h1;
      s_axil_awaddr  <= a;
      s_axil_wvalid  <= 1'h1;
      s_axil_wdata   <= d;
      s_axil_bready  <= 1'h1;
      aw_t = 1'h0;
      w_t  = 1'h0;
      for (n = 0; n < 50 && !(aw_t && w_t); n++) begin
         @(negedge aclk);
         aw_t = aw_t || (s_axil_awvalid && s_axil_awready);
         w_t  = w_t || (s_axil_wvalid && s_axil_wready);
         @(posedge aclk);
         if (aw_t) s_axil_awvalid <= 1'h0;
         if (w_t) s_axil_wvalid <= 1'h0;
      end
      @(negedge aclk);
      for (n = 0; n < 50 && s_axil_bvalid !== 1'h1; n++) @(negedge aclk);
      // a write that never answers must count against the run
      chk_flag(s_axil_bvalid, 1'h1, "write answer");
      chk({30'h0, s_axil_bresp}, {30'h0, er}, "write response");
      @(posedge aclk);
      s_axil_bready <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axil_arvalid <= 1'h1;
      s_axil_araddr  <= a;
      s_axil_rready  <= 1'h1;
      @(negedge aclk);
      for (n = 0; n < 50 && s_axil_arready !== 1'h1; n++) @(negedge aclk);
      @(posedge aclk);
      s_axil_arvalid <= 1'h0;
      @(negedge aclk);
      for (n = 0; n < 32 && s_axil_rvalid !== 1'h1; n++) @(negedge aclk);
      chk_flag(s_axil_rvalid, 1'h1, "read answer");
      d = s_axil_rdata;
      chk({30'h0, s_axil_rresp}, {30'h0, er}, "read response");
      @(posedge aclk);
      s_axil_rready <= 1'h0;
   endtask : rd

   task automatic rdc(input logic [31:0] e);
      logic [31:0] d;
      rd(ADDR_CONTROL, RESP_OKAY, d);
      chk(d, e, "control read");
   endtask : rdc

   // one half-second tick; the pulse must flip exactly when an event is expected
   task automatic tick(input logic ev);
      logic p;
      p = alarm_pulse;
      @(posedge aclk);
      half_tick <= 1'h1;
      @(posedge aclk);
      half_tick <= 1'h0;
      #1;
      chk_flag(alarm_event, ev, "alarm event");
      chk_flag(alarm_pulse, p ^ ev, "alarm pulse");
      @(posedge aclk);
      #1;
      chk_flag(alarm_event, 1'h0, "event width");
   endtask : tick

   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (5000) @(posedge aclk);
      error_cnt++;
      $display("ERROR at %0t: watchdog expired", $time);
      end_of_test();
   end

   initial begin
      logic [31:0] t;
      logic [31:0] dt;
      logic [31:0] v;
      logic [15:0] near_tab [3];
      int          fp [10];
      int          k;
      near_tab = '{16'h0020, 16'h0021, 16'h0000};
      fp = '{0, 0, 8, 12, 16, 20, 24, 0, 8, 16};
      repeat (6) @(posedge aclk);
      aresetn    <= 1'h1;
      power_on_n <= 1'h1;
      rdc(32'h0);
      rd(8'h0C, RESP_SLVERR, v);
      chk(v, 32'h0, "unmapped read");
      wr(8'h0C, 32'hFFFFFFFF, RESP_SLVERR);
      rdc(32'h0);
      $display("test reset and map done");
      repeat (4) begin
         t  = rnd_time();
         dt = rnd_date();
         wr(ADDR_TIME, t | 32'hC08080FF, RESP_OKAY);
         wr(ADDR_DATE, dt | 32'hFFE0C0F8, RESP_OKAY);
         rd(ADDR_TIME, RESP_OKAY, v);
         chk(v, t, "alarm time");
         rd(ADDR_DATE, RESP_OKAY, v);
         chk(v, dt, "alarm date");
      end
      $display("test alarm setting done");
      wr(ADDR_CONTROL, ctl(0, 0, 1, 0, 4'h0, 8'h00), RESP_OKAY);
      chk_flag(alarm_pulse, 1'h1, "pulse start level");
      rdc(ctl(0, 0, 1, 0, 4'h0, 8'h00));
      wr(ADDR_CONTROL, ctl(1, 0, 1, 0, 4'h0, 8'h02), RESP_OKAY);
      wr(ADDR_CONTROL, ctl(1, 0, 0, 0, 4'h0, 8'h02), RESP_OKAY);
      chk_flag(alarm_pulse, 1'h1, "pulse kept while armed");
      rdc(ctl(1, 0, 1, 0, 4'h0, 8'h02));
      tick(1'h1);
      rdc(ctl(1, 0, 0, 0, 4'h0, 8'h01));
      tick(1'h1);
      rdc(ctl(1, 0, 1, 0, 4'h0, 8'h00));
      tick(1'h1);
      rdc(ctl(0, 0, 0, 0, 4'h0, 8'h00));
      tick(1'h0);
      $display("test countdown done");
      wr(ADDR_CONTROL, ctl(1, 1, 0, 0, 4'h0, 8'h00), RESP_OKAY);
      tick(1'h1);
      rdc(ctl(1, 1, 1, 0, 4'h0, 8'hFF));
      tick(1'h1);
      rdc(ctl(1, 1, 0, 0, 4'h0, 8'hFE));
      $display("test chime done");
      for (k = 0; k < 3; k++) begin
         @(posedge aclk);
         rtc_clocks_to_rollover <= near_tab[k];
         rdc(ctl(1, 1, 0, near_tab[k] <= 16'h0020, 4'h0, 8'hFE));
         // a second read must agree before software trusts the countdown
         rdc(ctl(1, 1, 0, near_tab[k] <= 16'h0020, 4'h0, 8'hFE));
      end
      @(posedge aclk);
      rtc_clocks_to_rollover <= 16'h0064;
      $display("test rollover flag done");
      // one matching tick per code, then for codes 1 to 9 a tick that misses only in the coarsest compared field
      for (k = 0; k < 10; k++) begin
         wr(ADDR_CONTROL, ctl(1, 1, 0, 0, 4'(k), 8'h03), RESP_OKAY);
         @(posedge aclk);
         now_time    <= t;
         now_date    <= dt;
         second_half <= 1'h0;
         tick(1'h1);
         if (k > 0) begin
            @(posedge aclk);
            if (k == 1) second_half <= 1'h1;
            else if (k < 7) now_time <= t ^ (32'h1 << fp[k]);
            else now_date <= dt ^ (32'h1 << fp[k]);
            tick(1'h0);
         end
      end
      $display("test match intervals done");
      // upper bits and the near flag are offered too; neither may stick
      wr(ADDR_CONTROL, ctl(0, 1, 1, 0, 4'h5, 8'h5A) | 32'hFFFF1000, RESP_OKAY);
      wr(ADDR_CONTROL, ctl(0, 1, 1, 0, 4'h5, 8'h5A), RESP_OKAY);
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rdc(ctl(0, 1, 1, 0, 4'h5, 8'h5A));
      rd(ADDR_TIME, RESP_OKAY, v);
      chk(v, t, "time after bus reset");
      @(posedge aclk);
      power_on_n <= 1'h0;
      repeat (2) @(posedge aclk);
      power_on_n <= 1'h1;
      rdc(32'h0);
      chk_flag(alarm_pulse, 1'h0, "pulse after power-on");
      $display("test resets done");
      end_of_test();
   end

endmodule : tb_top

`default_nettype wire
